// file: two_wire_slave_map.svh
// Offsets, field positions, reset values and status codes of the slave engine
`ifndef TWO_WIRE_SLAVE_MAP_SVH
`define TWO_WIRE_SLAVE_MAP_SVH
// Overview of operation
// - Status codes assume the prescaler field reads zero or is masked.
// - Own address in upper seven bits; bit 0 enables general call 0x00.
// - Matched address with read bit enters transmit, otherwise receive.
// - After address and direction acknowledged, flag set with valid status.
// - Lost arbitration then addressed for read reports 0xB0.
// - In 0x90 next general-call byte gets ACK if ack enable set.
// - In 0x98 drop to not-addressed after flag clear; exits per bits.
// - STOP or repeated START while addressed reports 0xA0, then not addressed.
// - Not addressed with ack enable 0: no own or general call match.
// - Not addressed with ack enable 1: own address, general call if enabled.
// - Start request set on leaving: queue START until bus is free.
// - Ack enable cleared in transmit: one last byte, then 0xC0 or 0xC8.
// - Master ACK after last byte gives 0xC8.
// - After last byte, ignore further clocks; data line released.
// - Ack enable zero ignores own address; recognition resumes when set.
// - In clock-stopped sleep, still acknowledge address and wake the part.
// - After wake-up match, hold clock low until flag cleared by one.
// - After clock-stopped sleep, data register need not hold bus byte.
// - In 0x60/0x80 next byte gets ACK if ack enable set, else NACK.
// - In 0x88 drop to not-addressed; exits as general-call NACK case.
// - In 0xA8/0xB8 send loaded byte; last one if ack enable zero.
`define TW_OFF_CTRL 2'h0
`define TW_OFF_STATUS 2'h1
`define TW_OFF_DATA 2'h2
`define TW_OFF_OWN 2'h3
`define TW_CTRL_RESET 8'h00
`define TW_OWN_RESET 8'hfe
`define TW_DATA_RESET 8'hff
`define TW_PRESC_LSB 0
`define TW_PRESC_MSB 1
`define TW_GCE_BIT 0
`define TW_ST_SLA_W 8'h60
`define TW_ST_ARB_SLA_W 8'h68
`define TW_ST_GC 8'h70
`define TW_ST_ARB_GC 8'h78
`define TW_ST_DATA_ACK 8'h80
`define TW_ST_DATA_NACK 8'h88
`define TW_ST_GC_ACK 8'h90
`define TW_ST_GC_NACK 8'h98
`define TW_ST_STOP 8'ha0
`define TW_ST_SLA_R 8'ha8
`define TW_ST_ARB_SLA_R 8'hb0
`define TW_ST_TX_ACK 8'hb8
`define TW_ST_TX_NACK 8'hc0
`define TW_ST_LAST_ACK 8'hc8
`define TW_ST_NONE 8'hf8
`endif

// file: two_wire_slave_pkg.sv
// Types shared by the slave engine
`default_nettype none
package two_wire_slave_pkg;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h0, ST_ADDR = 4'h1, ST_AACK = 4'h3, ST_HOLD = 4'h2,
      ST_RX = 4'h6, ST_RXACK = 4'h7, ST_TX = 4'h5, ST_TXACK = 4'h4,
      ST_IGNORE = 4'hc
   } state_t;
   typedef struct packed {
      logic flag;
      logic ack_en;
      logic start_req;
      logic stop_req;
      logic rsv3;
      logic enable;
      logic rsv1;
      logic int_en;
   } ctrl_t;
   typedef struct packed {
      logic [1:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;
endpackage : two_wire_slave_pkg
`default_nettype wire

// file: two_wire_slave_engine.sv
// Two-wire slave engine: receiver tail, transmitter, register port
`include "two_wire_slave_map.svh"
`default_nettype none
module two_wire_slave_engine
   import two_wire_slave_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // Register port
   input wire reg_req_t req,
   output logic [7:0] rdata,
   // Bus pins, open drain
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   // Master side and power
   input wire logic arb_lost,
   input wire logic sleep_stopped,
   output logic wake_request,
   output logic start_launch
);
   ////////////////////////////////////////////////////////////////////////////
   state_t state_q;
   ctrl_t ctrl_q;
   logic [7:0] own_q, data_q, status_q, sh_q, txsh_q, rdata_q, ev_code;
   logic [1:0] presc_q;
   logic [3:0] bitcnt_q;
   logic scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;
   logic dir_q, gc_q, arb_q, last_q, nack_q, ack_plan_q, addressed_q;
   logic start_pend_q, bus_free_q, sda_oe_q, scl_oe_q, wake_q;
   logic scl_rise, scl_fall, start_det, stop_det, ev_set;
   logic match_own, match_gc, addr_hit, flag_clear, hold_done, is_tx, is_rx;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         {scl_s1, scl_s2, scl_s3} <= 3'h7;
         {sda_s1, sda_s2, sda_s3} <= 3'h7;
      end else begin
         {scl_s1, scl_s2, scl_s3} <= {scl_i, scl_s1, scl_s2};
         {sda_s1, sda_s2, sda_s3} <= {sda_i, sda_s1, sda_s2};
      end
   end

   assign scl_rise = scl_s2 & ~scl_s3;
   assign scl_fall = ~scl_s2 & scl_s3;
   assign start_det = scl_s2 & scl_s3 & ~sda_s2 & sda_s3;
   assign stop_det = scl_s2 & scl_s3 & sda_s2 & ~sda_s3;

   ////////////////////////////////////////////////////////////////////////////
   // Address match
   // general call gate
   assign match_gc = (sh_q[7:1] == 7'h00) & own_q[`TW_GCE_BIT] & ~sh_q[0];
   assign match_own = (sh_q[7:1] == own_q[7:1]) & (sh_q[7:1] != 7'h00);
   assign addr_hit = ctrl_q.ack_en & (match_own | match_gc);
   assign flag_clear = req.wr & (req.addr == `TW_OFF_CTRL) & req.wdata[7];
   assign hold_done = (state_q == ST_HOLD) & ~ctrl_q.flag;
   assign is_tx = (status_q == `TW_ST_SLA_R) | (status_q == `TW_ST_ARB_SLA_R)
                | (status_q == `TW_ST_TX_ACK);
   assign is_rx = (status_q == `TW_ST_SLA_W) | (status_q == `TW_ST_ARB_SLA_W)
                | (status_q == `TW_ST_GC) | (status_q == `TW_ST_ARB_GC)
                | (status_q == `TW_ST_DATA_ACK) | (status_q == `TW_ST_GC_ACK);

   ////////////////////////////////////////////////////////////////////////////
   // Bus events and status codes
   always_comb begin
      ev_set = 1'b0;
      ev_code = `TW_ST_NONE;
      if (addressed_q & (start_det | stop_det)) begin
         ev_set = 1'b1;
         ev_code = `TW_ST_STOP;
      end else if (scl_fall) begin
         case (state_q)
            ST_AACK: begin
               ev_set = 1'b1;
               if (dir_q)
                  ev_code = arb_q ? `TW_ST_ARB_SLA_R : `TW_ST_SLA_R;
               else if (gc_q)
                  ev_code = arb_q ? `TW_ST_ARB_GC : `TW_ST_GC;
               else
                  ev_code = arb_q ? `TW_ST_ARB_SLA_W : `TW_ST_SLA_W;
            end
            ST_RXACK: begin
               ev_set = 1'b1;
               if (ack_plan_q)
                  ev_code = gc_q ? `TW_ST_GC_ACK : `TW_ST_DATA_ACK;
               else
                  ev_code = gc_q ? `TW_ST_GC_NACK : `TW_ST_DATA_NACK;
            end
            ST_TXACK: begin
               ev_set = 1'b1;
               if (nack_q)
                  ev_code = `TW_ST_TX_NACK;
               else
                  ev_code = last_q ? `TW_ST_LAST_ACK : `TW_ST_TX_ACK;
            end
            default: begin
               ev_set = 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Engine state machine
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= ST_IDLE;
         bitcnt_q <= 4'h0;
         sh_q <= 8'h00;
         txsh_q <= 8'hff;
         dir_q <= 1'b0;
         gc_q <= 1'b0;
         last_q <= 1'b0;
         nack_q <= 1'b1;
         ack_plan_q <= 1'b0;
      end else if (!ctrl_q.enable) begin
         state_q <= ST_IDLE;
         bitcnt_q <= 4'h0;
      end else if (start_det) begin
         state_q <= ST_ADDR;
         bitcnt_q <= 4'h0;
      end else if (stop_det & (state_q != ST_HOLD)) begin
         state_q <= ST_IDLE;
      end else begin
         case (state_q)
            ST_ADDR: begin
               if (scl_rise) begin
                  sh_q <= {sh_q[6:0], sda_s2};
                  bitcnt_q <= bitcnt_q + 4'h1;
               end else if (scl_fall & (bitcnt_q == 4'h8)) begin
                  state_q <= addr_hit ? ST_AACK : ST_IGNORE;
                  dir_q <= sh_q[0];
                  gc_q <= match_gc;
                  bitcnt_q <= 4'h0;
               end
            end
            ST_AACK: begin
               if (scl_fall)
                  state_q <= ST_HOLD;
            end
            ST_HOLD: begin
               if (!ctrl_q.flag) begin
                  if (is_tx) begin
                     state_q <= ST_TX;
                     txsh_q <= data_q;
                     last_q <= ~ctrl_q.ack_en;
                  end else if (is_rx) begin
                     state_q <= ST_RX;
                     ack_plan_q <= ctrl_q.ack_en;
                  end else begin
                     state_q <= ST_IDLE;
                  end
               end
            end
            ST_RX: begin
               if (scl_rise) begin
                  sh_q <= {sh_q[6:0], sda_s2};
                  bitcnt_q <= bitcnt_q + 4'h1;
               end else if (scl_fall & (bitcnt_q == 4'h8)) begin
                  state_q <= ST_RXACK;
                  bitcnt_q <= 4'h0;
               end
            end
            ST_RXACK: begin
               if (scl_fall)
                  state_q <= ST_HOLD;
            end
            ST_TX: begin
               if (scl_fall) begin
                  txsh_q <= {txsh_q[6:0], 1'b1};
                  bitcnt_q <= bitcnt_q + 4'h1;
                  if (bitcnt_q == 4'h7) begin
                     state_q <= ST_TXACK;
                     bitcnt_q <= 4'h0;
                  end
               end
            end
            ST_TXACK: begin
               if (scl_rise)
                  nack_q <= sda_s2;
               else if (scl_fall)
                  state_q <= ST_HOLD;
            end
            default: begin
               // idle and ignore keep the line released
               state_q <= state_q;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin drive
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         sda_oe_q <= 1'b0;
         scl_oe_q <= 1'b0;
      end else begin
         sda_oe_q <= (state_q == ST_AACK) | ((state_q == ST_RXACK) & ack_plan_q)
                   | ((state_q == ST_TX) & ~txsh_q[7]);
         scl_oe_q <= (state_q == ST_HOLD) & ctrl_q.flag;
      end
   end

   assign sda_oe = sda_oe_q;
   assign scl_oe = scl_oe_q;
   assign sda_o = 1'b0;
   assign scl_o = 1'b0;

   ////////////////////////////////////////////////////////////////////////////
   // Addressed, arbitration and bus-free tracking
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         addressed_q <= 1'b0;
         arb_q <= 1'b0;
         bus_free_q <= 1'b1;
      end else begin
         if (ev_set)
            addressed_q <= (ev_code != `TW_ST_STOP) & (ev_code != `TW_ST_DATA_NACK)
                         & (ev_code != `TW_ST_GC_NACK) & (ev_code != `TW_ST_TX_NACK)
                         & (ev_code != `TW_ST_LAST_ACK);
         if (arb_lost)
            arb_q <= 1'b1;
         else if (ev_set)
            arb_q <= 1'b0;
         if (stop_det)
            bus_free_q <= 1'b1;
         else if (start_det)
            bus_free_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Queued start
   // launch when bus free
   assign start_launch = start_pend_q & bus_free_q;
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n)
         start_pend_q <= 1'b0;
      else if (hold_done & ~is_tx & ~is_rx & ctrl_q.start_req)
         start_pend_q <= 1'b1;
      else if (start_launch)
         start_pend_q <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Wake request
   // wake the part on a match
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n)
         wake_q <= 1'b0;
      else if (ev_set & sleep_stopped)
         wake_q <= 1'b1;
      else if (!sleep_stopped)
         wake_q <= 1'b0;
   end
   assign wake_request = wake_q;

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_q <= `TW_CTRL_RESET;
      end else begin
         if (req.wr & (req.addr == `TW_OFF_CTRL)) begin
            ctrl_q <= req.wdata;
            ctrl_q.rsv3 <= 1'b0;
            ctrl_q.rsv1 <= 1'b0;
            ctrl_q.flag <= ctrl_q.flag & ~flag_clear;
         end
         // Hardware set wins over software clear
         if (ev_set)
            ctrl_q.flag <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         own_q <= `TW_OWN_RESET;
         presc_q <= 2'h0;
         status_q <= `TW_ST_NONE;
      end else begin
         if (req.wr & (req.addr == `TW_OFF_OWN))
            own_q <= req.wdata;
         if (req.wr & (req.addr == `TW_OFF_STATUS))
            presc_q <= req.wdata[`TW_PRESC_MSB:`TW_PRESC_LSB];
         if (ev_set)
            status_q <= ev_code;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n)
         data_q <= `TW_DATA_RESET;
      else if ((state_q == ST_RX) & scl_fall & (bitcnt_q == 4'h8) & ~sleep_stopped)
         data_q <= sh_q;
      else if (req.wr & (req.addr == `TW_OFF_DATA))
         data_q <= req.wdata;
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n)
         rdata_q <= 8'h00;
      else if (req.rd) begin
         case (req.addr)
            `TW_OFF_CTRL: rdata_q <= ctrl_q;
            `TW_OFF_STATUS: rdata_q <= {status_q[7:3], 1'b0, presc_q};
            `TW_OFF_DATA: rdata_q <= data_q;
            default: rdata_q <= own_q;
         endcase
      end else
         rdata_q <= 8'h00;
   end
   assign rdata = rdata_q;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   clk_stretch_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (state_q == ST_HOLD) & ctrl_q.flag |=> scl_oe) else $error("clock not held");
   gc_ignore_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (state_q == ST_ADDR) & scl_fall & (bitcnt_q == 4'h8) & (sh_q == 8'h00)
      & ~own_q[0] & ~start_det & ctrl_q.enable |=> state_q == ST_IGNORE)
      else $error("general call answered");
   no_addr_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (state_q == ST_ADDR) & scl_fall & (bitcnt_q == 4'h8) & ~ctrl_q.ack_en
      & ~start_det & ctrl_q.enable |=> state_q == ST_IGNORE)
      else $error("address answered without ack enable");
   arb_read_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (state_q == ST_AACK) & scl_fall & dir_q & arb_q & ~addressed_q
      |=> ctrl_q.flag && status_q == `TW_ST_ARB_SLA_R) else $error("no 0xb0");
   rx_ack_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (state_q == ST_RXACK) & ack_plan_q & ~start_det & ~stop_det |=> sda_oe)
      else $error("ack not driven");
   rx_nack_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (state_q == ST_RXACK) & ~ack_plan_q |=> !sda_oe)
      else $error("nack not released");
   stop_code_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      addressed_q & stop_det |=> status_q == `TW_ST_STOP && !addressed_q)
      else $error("no 0xa0");
   last_ack_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (state_q == ST_TXACK) & scl_fall & ~nack_q & last_q & ~addressed_q == 1'b0
      & ~start_det & ~stop_det |=> status_q == `TW_ST_LAST_ACK)
      else $error("no 0xc8");
   idle_release_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (state_q == ST_IDLE) [*2] |-> !sda_oe) else $error("line driven when idle");
endmodule : two_wire_slave_engine
`default_nettype wire

// file: bus_master_model.sv
// Behavioural two-wire bus master on the far side of the slave engine
`default_nettype none
module bus_master_model
(
   // Clock
   input wire logic sys_clk,
   // Resolved bus lines
   input wire logic scl_line,
   input wire logic sda_line,
   // Open-drain drives, high releases
   output logic scl_drv,
   output logic sda_drv,
   // Stretch waits that ran out
   output int hangs
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      scl_drv = 1'b1;
      sda_drv = 1'b1;
      hangs = 0;
   end
   ////////////////////////////////////////////////////////////
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : tick
   // Release the clock, wait out a stretch
   task automatic rise;
      int k;
      k = 0;
      scl_drv <= 1'b1;
      do begin
         @(posedge sys_clk);
         k++;
      end while (scl_line !== 1'b1 && k < 3000);
      if (k >= 3000) hangs++;
   endtask : rise
   // One bit: data set while low, sampled late in high phase
   task automatic bit_cycle(input logic b, output logic s);
      tick(3);
      sda_drv <= b;
      tick(3);
      rise;
      tick(1);
      s = sda_line;
      scl_drv <= 1'b0;
   endtask : bit_cycle
   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_cycle(b[i], s);
      bit_cycle(1'b1, s);
      ack = ~s;
      tick(4);
   endtask : send_byte
   task automatic recv_byte(input logic ack, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_cycle(1'b1, s);
         b[i] = s;
      end
      bit_cycle(~ack, s);
      tick(4);
   endtask : recv_byte
   task automatic start_cond;
      sda_drv <= 1'b1;
      tick(3);
      rise;
      tick(3);
      sda_drv <= 1'b0;
      tick(3);
      scl_drv <= 1'b0;
   endtask : start_cond
   task automatic stop_cond;
      tick(3);
      sda_drv <= 1'b0;
      tick(3);
      rise;
      tick(3);
      sda_drv <= 1'b1;
      tick(8);
   endtask : stop_cond
endmodule : bus_master_model
`default_nettype wire

// file: tb_top.sv
// Self-checking bench for the two-wire slave engine
`default_nettype none
`define check_eq(got, exp) \
   begin \
      checks_done++; \
      if ((got) !== (exp)) begin \
         error_cnt++; \
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp); \
      end \
   end
module tb_top
   import two_wire_slave_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk = 1'b0;
   logic reset_n, arb_lost, sleep_stopped, scl_o, scl_oe, sda_o, sda_oe;
   logic wake_request, start_launch, scl_drv, sda_drv, ack, launched;
   wire logic scl_line;
   wire logic sda_line;
   reg_req_t req;
   logic [7:0] rdata, d;
   int hangs;
   int error_cnt = 0;
   int checks_done = 0;
   assign scl_line = scl_drv & ~(scl_oe & ~scl_o);
   assign sda_line = sda_drv & ~(sda_oe & ~sda_o);
   initial forever #50 sys_clk = ~sys_clk;
   two_wire_slave_engine i_dut (
      .sys_clk(sys_clk), .reset_n(reset_n), .req(req), .rdata(rdata),
      .scl_i(scl_line), .scl_o(scl_o), .scl_oe(scl_oe),
      .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
      .arb_lost(arb_lost), .sleep_stopped(sleep_stopped),
      .wake_request(wake_request), .start_launch(start_launch)
   );
   bus_master_model i_master (
      .sys_clk(sys_clk), .scl_line(scl_line), .sda_line(sda_line),
      .scl_drv(scl_drv), .sda_drv(sda_drv), .hangs(hangs)
   );
   ////////////////////////////////////////////////////////////
   task automatic reg_wr(input logic [1:0] a, input logic [7:0] v);
      @(posedge sys_clk);
      req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk);
      req.wr <= 1'b0;
   endtask : reg_wr
   task automatic reg_rd(input logic [1:0] a, output logic [7:0] v);
      @(posedge sys_clk);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk);
      req.rd <= 1'b0;
      @(posedge sys_clk);
      v = rdata;
   endtask : reg_rd
   task automatic expect_reg(input logic [1:0] a, input logic [7:0] e);
      reg_rd(a, d);
      `check_eq(d, e)
   endtask : expect_reg
   task automatic address(input logic [7:0] b, input logic e);
      i_master.start_cond();
      i_master.send_byte(b, ack);
      `check_eq(ack, e)
   endtask : address
   task automatic done(input string s);
      $display("Test %s finished", s);
   endtask : done
   task automatic give_verdict;
      `check_eq(hangs, 0)
      $display("Checks %0d, mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : give_verdict
   ////////////////////////////////////////////////////////////
   initial begin
      reset_n = 1'b0;
      req = '0;
      arb_lost = 1'b0;
      sleep_stopped = 1'b0;
      repeat (12) @(posedge sys_clk);
      reset_n <= 1'b1;
      expect_reg(2'h0, 8'h00);
      expect_reg(2'h1, 8'hf8);
      expect_reg(2'h2, 8'hff);
      expect_reg(2'h3, 8'hfe);
      reg_wr(2'h1, 8'h03);
      expect_reg(2'h1, 8'hfb);
      reg_wr(2'h1, 8'h00);
      reg_wr(2'h0, 8'h5f);
      expect_reg(2'h0, 8'h55);
      reg_wr(2'h3, 8'h53);
      reg_wr(2'h0, 8'h44);
      done("registers");
      address(8'h53, 1'b1);
      expect_reg(2'h1, 8'ha8);
      `check_eq(scl_oe, 1'b1)
      reg_wr(2'h2, 8'ha5);
      reg_wr(2'h0, 8'hc4);
      i_master.recv_byte(1'b1, d);
      `check_eq(d, 8'ha5)
      expect_reg(2'h1, 8'hb8);
      reg_wr(2'h2, 8'h3c);
      reg_wr(2'h0, 8'h84);
      i_master.recv_byte(1'b1, d);
      `check_eq(d, 8'h3c)
      expect_reg(2'h1, 8'hc8);
      reg_wr(2'h0, 8'hc4);
      i_master.recv_byte(1'b0, d);
      `check_eq(d, 8'hff)
      i_master.stop_cond();
      expect_reg(2'h0, 8'h44);
      done("transmit");
      address(8'h52, 1'b1);
      expect_reg(2'h1, 8'h60);
      reg_wr(2'h0, 8'hc4);
      i_master.send_byte(8'h12, ack);
      `check_eq(ack, 1'b1)
      expect_reg(2'h1, 8'h80);
      expect_reg(2'h2, 8'h12);
      reg_wr(2'h0, 8'h84);
      i_master.send_byte(8'h34, ack);
      `check_eq(ack, 1'b0)
      expect_reg(2'h1, 8'h88);
      reg_wr(2'h0, 8'he4);
      fork
         i_master.stop_cond();
         begin
            for (int k = 0; k < 40 && start_launch !== 1'b1; k++) @(posedge sys_clk);
            launched = start_launch;
         end
      join
      `check_eq(launched, 1'b1)
      reg_wr(2'h0, 8'h44);
      done("receive");
      address(8'h00, 1'b1);
      expect_reg(2'h1, 8'h70);
      reg_wr(2'h0, 8'hc4);
      i_master.send_byte(8'h55, ack);
      `check_eq(ack, 1'b1)
      expect_reg(2'h1, 8'h90);
      reg_wr(2'h0, 8'h84);
      i_master.send_byte(8'h66, ack);
      `check_eq(ack, 1'b0)
      expect_reg(2'h1, 8'h98);
      reg_wr(2'h0, 8'h84);
      address(8'h52, 1'b0);
      reg_wr(2'h0, 8'h44);
      address(8'h52, 1'b1);
      expect_reg(2'h1, 8'h60);
      reg_wr(2'h0, 8'hc4);
      i_master.stop_cond();
      expect_reg(2'h1, 8'ha0);
      reg_wr(2'h0, 8'hc4);
      reg_wr(2'h3, 8'h52);
      address(8'h00, 1'b0);
      i_master.stop_cond();
      done("general call");
      @(posedge sys_clk);
      arb_lost <= 1'b1;
      @(posedge sys_clk);
      arb_lost <= 1'b0;
      address(8'h53, 1'b1);
      expect_reg(2'h1, 8'hb0);
      reg_wr(2'h2, 8'h81);
      reg_wr(2'h0, 8'hc4);
      i_master.recv_byte(1'b0, d);
      `check_eq(d, 8'h81)
      expect_reg(2'h1, 8'hc0);
      reg_wr(2'h0, 8'hc4);
      i_master.stop_cond();
      @(posedge sys_clk);
      arb_lost <= 1'b1;
      @(posedge sys_clk);
      arb_lost <= 1'b0;
      address(8'h52, 1'b1);
      expect_reg(2'h1, 8'h68);
      reg_wr(2'h0, 8'hc4);
      i_master.stop_cond();
      expect_reg(2'h1, 8'ha0);
      reg_wr(2'h0, 8'hc4);
      done("arbitration");
      sleep_stopped <= 1'b1;
      address(8'h52, 1'b1);
      expect_reg(2'h1, 8'h60);
      `check_eq(wake_request, 1'b1)
      sleep_stopped <= 1'b0;
      repeat (4) @(posedge sys_clk);
      `check_eq(wake_request, 1'b0)
      `check_eq(scl_oe, 1'b1)
      reg_wr(2'h0, 8'hc4);
      repeat (4) @(posedge sys_clk);
      `check_eq(scl_oe, 1'b0)
      i_master.stop_cond();
      expect_reg(2'h1, 8'ha0);
      reg_wr(2'h0, 8'hc4);
      done("sleep");
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire
